// ---- hw/ums_top.sv ----
// Modem signal logic: serial line routing, handshake input status with
// change flags and interrupt request, handshake outputs from control bits.
// Assumes handshake inputs may be asynchronous, the rest synchronous to mclk; framing and baud logic sit outside.
`timescale 1ns/1ps

module ums_top #(
  parameter int unsigned VARIANT = ums_pkg::VAR_FULL
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire ums_pkg::ums_req_t           reg_req,
  output logic [ums_pkg::DATA_W-1:0]       reg_rdata,
  input  wire logic                        msi_enable,
  output logic                             msi_request,
  input  wire ums_pkg::ums_hs_in_t         hs_in,
  input  wire logic                        serial_in,
  output logic                             serial_out,
  input  wire logic                        uart_tx,
  input  wire logic                        ir_tx,
  output logic                             uart_rx,
  output logic                             ir_rx,
  output logic                             terminal_ready_out_n,
  output logic                             send_request_out_n
);

  localparam bit HAS_FULL = (VARIANT == ums_pkg::VAR_FULL);
  localparam bit HAS_CTS  = (VARIANT != ums_pkg::VAR_BASIC);

  logic [ums_pkg::MC_W-1:0]   modem_ctrl;
  logic [ums_pkg::PM_W-1:0]   port_mode;
  logic [3:0]                 present_mask;
  logic [3:0]                 raw_in;
  logic [3:0]                 sync_a;
  logic [3:0]                 sync_b;
  logic [3:0]                 level_q;
  logic [3:0]                 status;
  logic [3:0]                 edge_set;
  logic [3:0]                 chg;
  logic [ums_pkg::DATA_W-1:0] state_word;
  logic [ums_pkg::DATA_W-1:0] ctrl_word;
  logic [ums_pkg::DATA_W-1:0] mode_word;
  logic [ums_pkg::DATA_W-1:0] next_rdata;
  logic                       ctrl_wr;
  logic                       mode_wr;
  logic                       state_rd;
  logic                       infrared;
  logic                       loop_mode;
  logic                       cts_edge;
  logic                       dsr_edge;
  logic                       bell_trail;
  logic                       carrier_edge;
  logic                       cts_chg;
  logic                       dsr_chg;
  logic                       bell_te;
  logic                       carrier_chg;
  logic                       flag_pending;
  logic                       next_msi;
  logic                       next_serial_out;
  logic                       next_uart_rx;
  logic                       next_ir_rx;
  logic                       next_term_n;
  logic                       next_req_n;

  // Absent pins read as inactive (high), so status stays zero
  assign present_mask = {HAS_FULL, HAS_FULL, HAS_FULL, HAS_CTS};
  assign raw_in = {hs_in.carrier_n, hs_in.bell_n,
                   hs_in.peer_ready_n, hs_in.send_clear_n} | ~present_mask;

  assign infrared  = port_mode[ums_pkg::PM_INFRARED];
  assign loop_mode = modem_ctrl[ums_pkg::MC_LOOP];
  assign ctrl_wr   = reg_req.wr && (reg_req.addr == ums_pkg::OFS_MODEM_CTRL);
  assign mode_wr   = reg_req.wr && (reg_req.addr == ums_pkg::OFS_PORT_MODE);
  assign state_rd  = reg_req.rd && (reg_req.addr == ums_pkg::OFS_MODEM_STATE);

  // Control register: terminal ready, send request and loopback bits
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      modem_ctrl <= ums_pkg::MC_RESET;
    end else if (ctrl_wr) begin
      modem_ctrl <= reg_req.wdata[ums_pkg::MC_W-1:0];
    end
  end

  // Port mode register: infrared select
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      port_mode <= ums_pkg::PM_RESET;
    end else if (mode_wr) begin
      port_mode <= reg_req.wdata[ums_pkg::PM_W-1:0];
    end
  end

  // First stage may be metastable; only the second stage reads it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_a <= ums_pkg::SYNC_RESET;
    end else begin
      sync_a <= raw_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_b <= ums_pkg::SYNC_RESET;
    end else begin
      sync_b <= sync_a;
    end
  end

  // Last settled level for change detection; glitches still count
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      level_q <= ums_pkg::SYNC_RESET;
    end else begin
      level_q <= sync_b;
    end
  end

  // Status bits, carrier/bell/dsr/cts order, complement of the pins
  assign status = ~sync_b;

  // Bell flags its trailing pin edge only, the status bit falling
  assign cts_edge     = sync_b[0] ^ level_q[0];
  assign dsr_edge     = sync_b[1] ^ level_q[1];
  assign bell_trail   = sync_b[2] & ~level_q[2];
  assign carrier_edge = sync_b[3] ^ level_q[3];
  assign edge_set     = {carrier_edge, bell_trail, dsr_edge, cts_edge};

  // One flag per input; a state read clears all of them
  ums_chg_flag #(
    .RESET_VAL (ums_pkg::CHG_RESET[0])
  ) cts_flag_i (
    .mclk  (mclk),
    .rst_n (rst_n),
    .set   (cts_edge),
    .clear (state_rd),
    .flag  (cts_chg)
  );

  ums_chg_flag #(
    .RESET_VAL (ums_pkg::CHG_RESET[1])
  ) dsr_flag_i (
    .mclk  (mclk),
    .rst_n (rst_n),
    .set   (dsr_edge),
    .clear (state_rd),
    .flag  (dsr_chg)
  );

  ums_chg_flag #(
    .RESET_VAL (ums_pkg::CHG_RESET[2])
  ) bell_flag_i (
    .mclk  (mclk),
    .rst_n (rst_n),
    .set   (bell_trail),
    .clear (state_rd),
    .flag  (bell_te)
  );

  ums_chg_flag #(
    .RESET_VAL (ums_pkg::CHG_RESET[3])
  ) carrier_flag_i (
    .mclk  (mclk),
    .rst_n (rst_n),
    .set   (carrier_edge),
    .clear (state_rd),
    .flag  (carrier_chg)
  );

  assign chg = {carrier_chg, bell_te, dsr_chg, cts_chg};

  // Level request: stays up while msi_enable is high and any flag is pending after this edge
  always_comb begin
    flag_pending = (|edge_set) || (!state_rd && (|chg));
    next_msi     = msi_enable && flag_pending;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      msi_request <= 1'b0;
    end else begin
      msi_request <= next_msi;
    end
  end

  // State word assembled from the package field positions
  always_comb begin
    state_word = ums_pkg::RD_RESET;
    state_word[ums_pkg::MS_CTS_CHG]     = chg[0];
    state_word[ums_pkg::MS_DSR_CHG]     = chg[1];
    state_word[ums_pkg::MS_BELL_TE]     = chg[2];
    state_word[ums_pkg::MS_CARRIER_CHG] = chg[3];
    state_word[ums_pkg::MS_CTS]         = status[0];
    state_word[ums_pkg::MS_DSR]         = status[1];
    state_word[ums_pkg::MS_BELL]        = status[2];
    state_word[ums_pkg::MS_CARRIER]     = status[3];
  end

  // Read-back words; bits beyond each register read zero
  always_comb begin
    ctrl_word = ums_pkg::RD_RESET;
    ctrl_word[ums_pkg::MC_W-1:0] = modem_ctrl;
    mode_word = ums_pkg::RD_RESET;
    mode_word[ums_pkg::PM_W-1:0] = port_mode;
  end

  // Register read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = ums_pkg::RD_RESET;
    if (reg_req.rd) begin
      case (reg_req.addr)
        ums_pkg::OFS_MODEM_CTRL: begin
          next_rdata = ctrl_word;
        end
        ums_pkg::OFS_MODEM_STATE: begin
          next_rdata = state_word;
        end
        ums_pkg::OFS_PORT_MODE: begin
          next_rdata = mode_word;
        end
        default: begin
          next_rdata = ums_pkg::RD_RESET;
        end
      endcase
    end
  end

  // Read data stands for one cycle only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= ums_pkg::RD_RESET;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Serial routing; the transmit path has no handshake gating
  always_comb begin
    next_serial_out = infrared ? ir_tx : uart_tx;
    next_uart_rx    = infrared ? 1'b1 : serial_in;
    next_ir_rx      = infrared ? serial_in : 1'b1;
  end

  // Line idles marking while held in reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      serial_out <= 1'b1;
    end else begin
      serial_out <= next_serial_out;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      uart_rx <= 1'b1;
    end else begin
      uart_rx <= next_uart_rx;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ir_rx <= 1'b1;
    end else begin
      ir_rx <= next_ir_rx;
    end
  end

  // Handshake outputs; absent pins and loopback keep them inactive
  always_comb begin
    next_term_n = 1'b1;
    next_req_n  = 1'b1;
    if (!loop_mode) begin
      if (HAS_FULL && modem_ctrl[ums_pkg::MC_TERM_READY]) begin
        next_term_n = 1'b0;
      end
      if (HAS_CTS && modem_ctrl[ums_pkg::MC_SEND_REQ]) begin
        next_req_n = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      terminal_ready_out_n <= 1'b1;
    end else begin
      terminal_ready_out_n <= next_term_n;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      send_request_out_n <= 1'b1;
    end else begin
      send_request_out_n <= next_req_n;
    end
  end

endmodule

// Change flag: set by an edge, cleared by a state read; the set wins
module ums_chg_flag #(
  parameter bit RESET_VAL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);

  logic next_flag;

  always_comb begin
    next_flag = flag;
    if (clear) begin
      next_flag = 1'b0;
    end
    if (set) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag <= RESET_VAL;
    end else begin
      flag <= next_flag;
    end
  end

endmodule

// ---- hw/ums_pkg.sv ----
// Package for the modem signal logic: register offsets, field positions,
// reset values and port variants.
// Assumes a single 100 MHz clock domain and a plain register port.
package ums_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Word offsets on the register port
  localparam logic [ADDR_W-1:0] OFS_MODEM_CTRL  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MODEM_STATE = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_PORT_MODE   = 4'h8;

  // Modem control fields
  localparam int unsigned MC_TERM_READY = 0;
  localparam int unsigned MC_SEND_REQ   = 1;
  localparam int unsigned MC_LOOP       = 4;
  localparam int unsigned MC_W          = 5;

  // Port mode fields
  localparam int unsigned PM_INFRARED = 0;
  localparam int unsigned PM_W        = 1;

  // Modem state fields
  localparam int unsigned MS_CTS_CHG  = 0;
  localparam int unsigned MS_DSR_CHG  = 1;
  localparam int unsigned MS_BELL_TE  = 2;
  localparam int unsigned MS_CARRIER_CHG = 3;
  localparam int unsigned MS_CTS         = 4;
  localparam int unsigned MS_DSR         = 5;
  localparam int unsigned MS_BELL        = 6;
  localparam int unsigned MS_CARRIER     = 7;

  localparam logic [MC_W-1:0]   MC_RESET   = 5'h00;
  localparam logic [PM_W-1:0]   PM_RESET   = 1'h0;
  localparam logic [DATA_W-1:0] RD_RESET   = 8'h00;
  localparam logic [3:0]        SYNC_RESET = 4'hf;
  localparam logic [3:0]        CHG_RESET  = 4'h0;

  // Port variants
  localparam int unsigned VAR_FULL     = 0;
  localparam int unsigned VAR_WIRELESS = 1;
  localparam int unsigned VAR_BASIC    = 2;

  // Handshake inputs, active low, as they arrive
  typedef struct packed {
    logic carrier_n;
    logic bell_n;
    logic peer_ready_n;
    logic send_clear_n;
  } ums_hs_in_t;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ums_req_t;

endpackage

// ---- tb/ums_checker.sv ----
// Checker on the modem signal logic top ports.
// Assumes one clock and rst_n synchronous active low.
`timescale 1ns/1ps
module ums_checker (
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire ums_pkg::ums_req_t   reg_req,
  input wire logic [7:0]          reg_rdata,
  input wire logic                msi_enable,
  input wire logic                msi_request,
  input wire ums_pkg::ums_hs_in_t hs_in,
  input wire logic                serial_in,
  input wire logic                serial_out,
  input wire logic                uart_tx,
  input wire logic                ir_tx,
  input wire logic                uart_rx,
  input wire logic                terminal_ready_out_n,
  input wire logic                send_request_out_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire ctl_wr = reg_req.wr && reg_req.addr == ums_pkg::OFS_MODEM_CTRL;
  wire st_rd = reg_req.rd && reg_req.addr == ums_pkg::OFS_MODEM_STATE;
  AST_IDLE: assert property (
    $rose(rst_n) |-> serial_out && terminal_ready_out_n && send_request_out_n)
    else $error("outputs not idle");
  AST_STATUS: assert property (
    $past(st_rd) |-> (reg_rdata[7:4] ^ $past(hs_in, 3)) == 4'hf)
    else $error("status bits wrong");
  // Second cycle left free so either output latency passes
  AST_TERM: assert property (
    ctl_wr ##1 !ctl_wr |=> terminal_ready_out_n ==
    !($past(reg_req.wdata[0], 2) && !$past(reg_req.wdata[4], 2)))
    else $error("terminal ready wrong");
  AST_REQ: assert property (
    ctl_wr ##1 !ctl_wr |=> send_request_out_n ==
    !($past(reg_req.wdata[1], 2) && !$past(reg_req.wdata[4], 2)))
    else $error("send request wrong");
  AST_URX: assert property (
    !uart_rx |-> !$past(serial_in)) else $error("rx path wrong");
  AST_TXD: assert property (
    !serial_out |-> !$past(uart_tx) || !$past(ir_tx))
    else $error("tx path wrong");
  AST_MSI_EN: assert property (
    msi_request |-> $past(msi_enable)) else $error("ungated request");
  AST_MSI_SET: assert property (
    ($changed({hs_in.carrier_n, hs_in.peer_ready_n, hs_in.send_clear_n})
    || $rose(hs_in.bell_n)) ##2 msi_enable |=> msi_request)
    else $error("request missing");
endmodule

// ---- tb/ums_modem_model.sv ----
// Modem model: drives the handshake levels the bench asks for.
// Assumes levels change only at mclk rising edges.
`timescale 1ns/1ps
module ums_modem_model (
  input  wire logic          mclk,
  input  wire logic [3:0]    want,
  output ums_pkg::ums_hs_in_t hs
);
  // One clean step per edge, never a glitch
  always @(posedge mclk) hs <= want;
endmodule

// ---- tb/ums_top_bench.sv ----
// Bench: random port, line and handshake traffic against a model.
// Assumes the full variant and the checker bound below.
`timescale 1ns/1ps
module ums_top_bench;
  logic                mclk, rst_n, en, si, utx, itx, mpm;
  logic                msi, so, urx, irx, dtr_n, rts_n;
  logic                e_msi, e_so, e_urx, e_irx, e_dtr, e_rts;
  logic [4:0]          mctl;
  logic [3:0]          want, m1, m2, m3, mf, nf;
  logic [7:0]          exp_rd, rdata;
  logic [31:0]         r;
  int                  err_total, samples_checked;
  ums_pkg::ums_req_t   rq;
  ums_pkg::ums_hs_in_t hs;
  ums_modem_model ums_modem_model_i (.mclk(mclk), .want(want), .hs(hs));
  ums_top ums_top_i (.mclk(mclk), .rst_n(rst_n), .reg_req(rq),
    .reg_rdata(rdata), .msi_enable(en), .msi_request(msi), .hs_in(hs),
    .serial_in(si), .serial_out(so), .uart_tx(utx), .ir_tx(itx),
    .uart_rx(urx), .ir_rx(irx), .terminal_ready_out_n(dtr_n),
    .send_request_out_n(rts_n));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (!rst_n) begin
      {m1, m2, m3, mf, mpm, mctl} <= {12'hfff, 10'h000};
      {exp_rd, e_msi, e_so, e_urx, e_irx, e_dtr, e_rts} <= {8'h00, 6'h1f};
    end else begin
      // Set wins over the clear of a same-edge read
      nf = (rq.rd && rq.addr == ums_pkg::OFS_MODEM_STATE ? 4'h0 : mf)
        | ((m2 ^ m3) & 4'hb) | {1'b0, m2[2] & ~m3[2], 2'b00};
      {m1, m2, m3, mf} <= {hs, m1, m2, nf};
      e_msi <= en & |nf;
      exp_rd <= !rq.rd ? 8'h00
        : rq.addr == ums_pkg::OFS_MODEM_STATE ? {~m2, mf}
        : rq.addr == ums_pkg::OFS_MODEM_CTRL ? {3'h0, mctl}
        : rq.addr == ums_pkg::OFS_PORT_MODE ? {7'h00, mpm} : 8'h00;
      if (rq.wr && rq.addr == ums_pkg::OFS_PORT_MODE) mpm <= rq.wdata[0];
      if (rq.wr && rq.addr == ums_pkg::OFS_MODEM_CTRL) mctl <= rq.wdata[4:0];
      e_dtr <= ~(mctl[0] & ~mctl[4]);
      e_rts <= ~(mctl[1] & ~mctl[4]);
      e_so <= mpm ? itx : utx;
      e_urx <= mpm | si;
      e_irx <= ~mpm | si;
    end
  end
  always @(negedge mclk) begin
    if (rst_n) begin
      chk("state", exp_rd, rdata);
      chk("msi", e_msi, msi);
      chk("txd", e_so, so);
      chk("rx", {e_urx, e_irx}, {urx, irx});
      chk("dtr", e_dtr, dtr_n);
      chk("rts", e_rts, rts_n);
    end
  end
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {rst_n, en, si, utx, itx, want, rq} = {5'h0f, 4'hf, 14'h0000};
    void'($urandom(32'hb511baf6));
    repeat (20) @(posedge mclk);
    rst_n <= 1;
    repeat (4000) begin
      @(posedge mclk);
      r = $urandom;
      // Unmapped 0xf mixed in; a read and a write never share a cycle
      rq.addr <= r[2] ? ums_pkg::OFS_MODEM_STATE : r[3] ?
        ums_pkg::OFS_MODEM_CTRL : r[4] ? ums_pkg::OFS_PORT_MODE : 4'hf;
      rq.wr <= !r[2] && r[1:0] == 2'd1;
      rq.rd <= r[2] || r[1:0] == 2'd2;
      rq.wdata <= r[15:8];
      {en, si, utx, itx} <= {r[16] | r[17], r[20:18]};
      if (r[23:21] == 3'd0) want <= want ^ r[27:24];
    end
    end_sim;
  end
endmodule
bind ums_top ums_checker ums_checker_i (.mclk, .rst_n, .reg_req,
  .reg_rdata, .msi_enable, .msi_request, .hs_in, .serial_in, .serial_out,
  .uart_tx, .ir_tx, .uart_rx, .terminal_ready_out_n, .send_request_out_n);
